// file: rtl/pwm_wave_consts.svh
// constants of the pulse width modulation wave counter
// What this block does
// - one shared 15-bit counter feeds four compare channels, one common period
// - counter runs up only or up then down, chosen by the mode control bit
// - counter top value and prescaled clock together set the output period
// - top below a channel's compare gives no edges; high first stays high
// - compare registers are internal, loaded only from the sequence memory, except channel 3 in load mode a, which is loaded with zero
// - counter top register may be written anytime; it is used only when sampled
// - in load mode a the top value comes from memory, register ignored
// - other load modes sample the top register at start and every memory load
// - up mode wraps to zero at top and each output with compare above zero and below top toggles there
// - high first: compare zero stays low, compare equal to top stays high
// - up mode pulses of all channels are edge aligned at the wrap point
// - up mode period is top prescaled ticks, resolution one tick
// - up-down mode counts back to zero, second match toggles, center aligned
// - up-down mode period is twice top ticks, resolution two ticks
// - each channel but channel 3 in load mode a takes its polarity from memory with its duty value
// - polarity, duty and period may change every period without software
// - memory entry holds polarity in bit 15 and compare in bits 14 to 0
// - load mode a reads four words per step: three compares and the top
// - stop finishes the current period, then halted event and idle pin levels
`ifndef PWM_WAVE_CONSTS_SVH
`define PWM_WAVE_CONSTS_SVH

// ==========================================
// sizes
`define ADDR_W 9
`define CNT_W 15
`define NUM_CH 4
`define ENTRY_W 16
`define MAX_MEM_DEPTH 64

// ==========================================
// register byte offsets
`define OFF_CTRL 9'h000
`define OFF_PRESC 9'h004
`define OFF_TOP 9'h008
`define OFF_SEQ_LEN 9'h00C
`define OFF_TASK 9'h010
`define OFF_STATUS 9'h014
`define MEM_SEL_BIT 8

// ==========================================
// fields
`define CTRL_UPDOWN_BIT 0
`define CTRL_LOAD_LSB 1
`define CTRL_IDLE_LSB 4
`define TASK_START_BIT 0
`define TASK_STOP_BIT 1
`define STAT_RUN_BIT 0
`define STAT_STOPPING_BIT 1
`define STAT_SEQEND_BIT 2
`define STAT_OUT_LSB 8
`define STAT_CNT_LSB 16

// ==========================================
// encodings and reset values
`define LOAD_COMMON 2'h0
`define LOAD_INDIVIDUAL 2'h1
`define LOAD_MODE_A 2'h2
`define LOAD_RESERVED 2'h3
`define TOP_RESET 15'h03FF
`define STEP_COMMON 7'h01
`define STEP_GROUPED 7'h04
`define TOP_SLOT 3

`endif

// file: rtl/pwm_wave_pkg.sv
// types shared by the wave counter files
`include "pwm_wave_consts.svh"
package pwm_wave_pkg;

  typedef enum logic [1:0] {
    load_common = `LOAD_COMMON,
    load_individual = `LOAD_INDIVIDUAL,
    load_mode_a = `LOAD_MODE_A,
    load_reserved = `LOAD_RESERVED
  } load_mode_t;

  typedef enum logic [2:0] {
    st_idle = 3'b001,
    st_run = 3'b010,
    st_stopping = 3'b100
  } run_state_t;

  typedef struct packed {
    logic pol;
    logic [`CNT_W-1:0] val;
  } cmp_entry_t;

endpackage

// file: rtl/pwm_prescaler.sv
// base clock divider producing the counter tick
`timescale 1ns/1ps
`default_nettype none
module pwm_prescaler #(
  parameter int DIV_W = 3
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  // control
  input wire logic clear,
  input wire logic [DIV_W-1:0] div_exp,
  // tick
  output logic tick
);
  localparam int CW = (1 << DIV_W) - 1;

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] mask;

  if (DIV_W < 1 || DIV_W > 4) begin : g_chk
    $error("pwm_prescaler: DIV_W out of range");
  end

  // divide by two to the power div_exp
  assign mask = ~({CW{1'b1}} << div_exp);
  assign tick = (cnt_r >= mask);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= '0;
    end else if (ce) begin
      if (clear || tick) begin
        cnt_r <= '0;
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// file: rtl/pwm_channel.sv
// one compare channel: output level from counter and compare entry
`timescale 1ns/1ps
`default_nettype none
module pwm_channel
  import pwm_wave_pkg::*;
(
  // counter state
  input wire logic [`CNT_W-1:0] cnt,
  input wire logic [`CNT_W-1:0] top,
  // compare setting
  input wire cmp_entry_t setting,
  // level
  output logic level
);
  logic high_first;

  always_comb begin
    if (setting.val == '0) begin
      high_first = 1'b0;
    end else if (setting.val >= top) begin
      high_first = 1'b1;
    end else begin
      high_first = (cnt < setting.val);
    end
    level = high_first ^ setting.pol;
  end
endmodule
`default_nettype wire

// file: rtl/pwm_wave_counter.sv
// four channel wave counter with sequence memory and register slave
`timescale 1ns/1ps
`default_nettype none
module pwm_wave_counter
  import pwm_wave_pkg::*;
#(
  parameter int MEM_DEPTH = 64,
  parameter int DIV_W = 3
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  // register slave
  input wire logic [`ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // output pins
  output logic [`NUM_CH-1:0] pwm_out,
  // events
  output logic period_end_event,
  output logic seq_end_event,
  output logic halted_event
);
  localparam int IDX_W = $clog2(MEM_DEPTH);

  if (MEM_DEPTH < 4 || MEM_DEPTH > `MAX_MEM_DEPTH || (1 << IDX_W) != MEM_DEPTH) begin : g_chk
    $error("pwm_wave_counter: MEM_DEPTH must be a power of two from 4 to 64");
  end

  // ==========================================
  // state
  logic wait_r;
  logic [31:0] rdata_r;
  logic [31:0] rd_value;
  logic updown_r;
  load_mode_t load_r;
  logic [`NUM_CH-1:0] idle_r;
  logic [DIV_W-1:0] presc_r;
  logic [`CNT_W-1:0] top_reg_r;
  logic [IDX_W:0] len_r;
  logic [`ENTRY_W-1:0] mem [MEM_DEPTH];
  run_state_t state_r;
  logic [`CNT_W-1:0] cnt_r;
  logic down_r;
  logic [`CNT_W-1:0] top_act_r;
  cmp_entry_t cmp_r [`NUM_CH];
  cmp_entry_t cmp_nxt [`NUM_CH];
  logic [`CNT_W-1:0] top_mem;
  logic [IDX_W:0] ptr_r;
  logic seq_done_r;
  logic [`NUM_CH-1:0] pwm_r;
  logic period_r;
  logic seq_end_r;
  logic halted_r;

  // ==========================================
  // decode
  logic wr_en;
  logic rd_take;
  logic start_task;
  logic stop_task;
  logic running;
  logic tick;
  logic up_last;
  logic period_end;
  logic stop_done;
  logic do_load;
  logic [IDX_W:0] base;
  logic [6:0] step;
  logic [IDX_W+1:0] next_ptr;
  logic have_step;
  logic [`NUM_CH-1:0] level;
  logic mem_hit;
  logic [IDX_W-1:0] mem_idx;
  logic [`CNT_W-1:0] cnt_view;

  assign wr_en = write && !wait_r;
  assign rd_take = read && wait_r;
  assign mem_idx = address[IDX_W+1:2];
  assign mem_hit = address[`MEM_SEL_BIT] &&
                   ({1'b0, address[`MEM_SEL_BIT-1:2]} < 7'(MEM_DEPTH));
  assign start_task = wr_en && (address == `OFF_TASK) && writedata[`TASK_START_BIT];
  assign stop_task = wr_en && (address == `OFF_TASK) && writedata[`TASK_STOP_BIT];
  assign running = (state_r != st_idle);

  // ==========================================
  // register slave
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wait_r <= 1'b1;
    end else if (ce) begin
      wait_r <= !((read || write) && wait_r);
    end
  end

  always_comb begin
    rd_value = '0;
    if (mem_hit) begin
      rd_value[`ENTRY_W-1:0] = mem[mem_idx];
    end else if (address == `OFF_CTRL) begin
      rd_value[`CTRL_UPDOWN_BIT] = updown_r;
      rd_value[`CTRL_LOAD_LSB +: 2] = load_r;
      rd_value[`CTRL_IDLE_LSB +: `NUM_CH] = idle_r;
    end else if (address == `OFF_PRESC) begin
      rd_value[DIV_W-1:0] = presc_r;
    end else if (address == `OFF_TOP) begin
      rd_value[`CNT_W-1:0] = top_reg_r;
    end else if (address == `OFF_SEQ_LEN) begin
      rd_value[IDX_W:0] = len_r;
    end else if (address == `OFF_STATUS) begin
      rd_value[`STAT_RUN_BIT] = running;
      rd_value[`STAT_STOPPING_BIT] = (state_r == st_stopping);
      rd_value[`STAT_SEQEND_BIT] = seq_done_r;
      rd_value[`STAT_OUT_LSB +: `NUM_CH] = pwm_r;
      rd_value[`STAT_CNT_LSB +: `CNT_W] = cnt_r;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_r <= '0;
    end else if (ce && rd_take) begin
      rdata_r <= rd_value;
    end
  end

  // control registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      updown_r <= 1'b0;
      load_r <= load_common;
      idle_r <= '0;
      presc_r <= '0;
      top_reg_r <= `TOP_RESET;
      len_r <= '0;
    end else if (ce && wr_en) begin
      if (address == `OFF_CTRL) begin
        updown_r <= writedata[`CTRL_UPDOWN_BIT];
        load_r <= load_mode_t'(writedata[`CTRL_LOAD_LSB +: 2]);
        idle_r <= writedata[`CTRL_IDLE_LSB +: `NUM_CH];
      end else if (address == `OFF_PRESC) begin
        presc_r <= writedata[DIV_W-1:0];
      end else if (address == `OFF_TOP) begin
        top_reg_r <= writedata[`CNT_W-1:0];
      end else if (address == `OFF_SEQ_LEN) begin
        len_r <= writedata[IDX_W:0];
      end
    end
  end

  // sequence memory, reached only by software and the decoder
  always_ff @(posedge clk) begin
    if (ce && wr_en && mem_hit) begin
      mem[mem_idx] <= writedata[`ENTRY_W-1:0];
    end
  end

  // ==========================================
  // run control
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= st_idle;
    end else if (ce) begin
      if (start_task) begin
        state_r <= st_run;
      end else if (stop_task && state_r == st_run) begin
        state_r <= st_stopping;
      end else if (stop_done) begin
        state_r <= st_idle;
      end
    end
  end

  // ==========================================
  // counter
  pwm_prescaler #(
    .DIV_W(DIV_W)
  ) u_presc (
    .clk(clk),
    .reset_n(reset_n),
    .ce(ce),
    .clear(!running || start_task),
    .div_exp(presc_r),
    .tick(tick)
  );

  assign up_last = ({1'b0, cnt_r} + 16'h0001) >= {1'b0, top_act_r};
  assign period_end = tick && running && ((updown_r && top_act_r != '0) ?
                      (down_r && cnt_r <= `CNT_W'(1)) : up_last);
  assign stop_done = period_end && (state_r == st_stopping);
  // down phase shows one less, so both halves of a period hold equal ticks
  assign cnt_view = down_r ? cnt_r - 1'b1 : cnt_r;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= '0;
      down_r <= 1'b0;
    end else if (ce) begin
      if (start_task) begin
        cnt_r <= '0;
        down_r <= 1'b0;
      end else if (tick && running) begin
        if (!updown_r || top_act_r == '0) begin
          cnt_r <= up_last ? '0 : cnt_r + 1'b1;
          down_r <= 1'b0;
        end else if (!down_r) begin
          cnt_r <= cnt_r + 1'b1;
          down_r <= up_last;
        end else begin
          cnt_r <= cnt_r - 1'b1;
          down_r <= (cnt_r > `CNT_W'(1));
        end
      end
    end
  end

  // ==========================================
  // decoder: fetch the next step from memory
  assign do_load = start_task || (period_end && state_r == st_run);
  assign base = start_task ? '0 : ptr_r;
  assign step = (load_r == load_common) ? `STEP_COMMON : `STEP_GROUPED;
  assign next_ptr = {1'b0, base} + (IDX_W+2)'(step);
  assign have_step = next_ptr <= {1'b0, len_r};
  assign top_mem = mem[IDX_W'(base + `TOP_SLOT)][`CNT_W-1:0];

  for (genvar i = 0; i < `NUM_CH; i++) begin : g_fetch
    always_comb begin
      if (load_r == load_common) begin
        cmp_nxt[i] = cmp_entry_t'(mem[IDX_W'(base)]);
      end else if (load_r == load_mode_a && i == `TOP_SLOT) begin
        cmp_nxt[i] = '0;
      end else begin
        cmp_nxt[i] = cmp_entry_t'(mem[IDX_W'(base + i)]);
      end
    end
  end

  // shadow loads land only on a period boundary or at start
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < `NUM_CH; i++) begin
        cmp_r[i] <= '0;
      end
      top_act_r <= `TOP_RESET;
      ptr_r <= '0;
    end else if (ce && do_load) begin
      if (have_step) begin
        for (int i = 0; i < `NUM_CH; i++) begin
          cmp_r[i] <= cmp_nxt[i];
        end
        ptr_r <= next_ptr[IDX_W:0];
      end
      if (load_r == load_mode_a) begin
        if (have_step) begin
          top_act_r <= top_mem;
        end
      end else if (start_task || have_step) begin
        top_act_r <= top_reg_r;
      end
    end
  end

  // ==========================================
  // channels and outputs
  for (genvar i = 0; i < `NUM_CH; i++) begin : g_ch
    pwm_channel u_ch (
      .cnt(cnt_view),
      .top(top_act_r),
      .setting(cmp_r[i]),
      .level(level[i])
    );
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pwm_r <= '0;
      period_r <= 1'b0;
      seq_end_r <= 1'b0;
      halted_r <= 1'b0;
      seq_done_r <= 1'b0;
    end else if (ce) begin
      pwm_r <= (!running || stop_done) ? idle_r : level;
      period_r <= period_end;
      seq_end_r <= do_load && have_step && ({1'b0, next_ptr} + (IDX_W+3)'(step) >
                   (IDX_W+3)'(len_r));
      halted_r <= stop_done || (stop_task && state_r == st_idle && !start_task);
      if (do_load && have_step && ({1'b0, next_ptr} + (IDX_W+3)'(step) >
          (IDX_W+3)'(len_r))) begin
        seq_done_r <= 1'b1;
      end else if (start_task) begin
        seq_done_r <= 1'b0;
      end
    end
  end

  assign readdata = rdata_r;
  assign waitrequest = wait_r;
  assign pwm_out = pwm_r;
  assign period_end_event = period_r;
  assign seq_end_event = seq_end_r;
  assign halted_event = halted_r;
endmodule
`default_nettype wire

// file: sim/pwm_pin_load.sv
// load model on the four output pins: counts high cycles and rising edges
`timescale 1ns/1ps
`default_nettype none
module pwm_pin_load (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // pins
  input wire logic [3:0] pins,
  // counts
  output logic [15:0] hi [4],
  output logic [15:0] rise [4]
);
  logic [3:0] last;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      last <= 4'h0;
      hi <= '{default: 16'h0};
      rise <= '{default: 16'h0};
    end else begin
      last <= pins;
      for (int c = 0; c < 4; c++) begin
        hi[c] <= hi[c] + 16'(pins[c]);
        rise[c] <= rise[c] + 16'(pins[c] & ~last[c]);
      end
    end
  end
endmodule
`default_nettype wire

// file: sim/pwm_wave_counter_sva.sv
// port checker of the wave counter
`timescale 1ns/1ps
`default_nettype none
`include "pwm_wave_consts.svh"
module pwm_wave_counter_sva (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  // register slave
  input wire logic [`ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // pins and events
  input wire logic [`NUM_CH-1:0] pwm_out,
  input wire logic period_end_event,
  input wire logic seq_end_event,
  input wire logic halted_event
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ==========================================
  // register slave
  a_wait_one: assert property ((read || write) && waitrequest && ce |=> !waitrequest)
    else $error("request not answered after one wait cycle");
  a_wait_short: assert property (!waitrequest && ce |=> waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_wait_idle: assert property (!read && !write && waitrequest |=> waitrequest)
    else $error("waitrequest low without a request");
  a_read_hold: assert property (!$stable(readdata) |-> read && !waitrequest)
    else $error("read data changed outside a read");
  // ==========================================
  // pins and events
  a_seq_pulse: assert property (seq_end_event |=> !seq_end_event)
    else $error("sequence end event longer than one cycle");
  a_halt_pulse: assert property (halted_event |=> !halted_event)
    else $error("halted event longer than one cycle");
  a_halt_idle: assert property (halted_event |=> $stable(pwm_out) ##1 $stable(pwm_out))
    else $error("pins moved around the halted event");
  a_ce_freeze: assert property (!ce |=> $stable(pwm_out) && $stable(waitrequest))
    else $error("state moved while clock enable low");
  c_period: cover property (period_end_event);
  c_seq: cover property (seq_end_event);
  c_halt: cover property (halted_event);
endmodule
`default_nettype wire

// file: sim/pwm_wave_counter_tb.sv
// testbench of the wave counter
`timescale 1ns/1ps
`default_nettype none
`include "pwm_wave_consts.svh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin failures++; \
  $display("Error at %0t: got %0h expected %0h", $time, a, e); end end
module pwm_wave_counter_tb;
  logic clk, reset_n, ce, read, write, waitrequest;
  logic [`ADDR_W-1:0] address;
  logic [31:0] writedata, readdata, q;
  logic [`NUM_CH-1:0] pwm_out;
  logic period_end_event, seq_end_event, halted_event;
  logic [15:0] hi [4];
  logic [15:0] rise [4];
  logic [15:0] dh [4];
  logic [15:0] dr [4];
  int failures, n_checks, clks, t;
  pwm_wave_counter #(.MEM_DEPTH(64), .DIV_W(3)) pwm_wave_counter_inst (.clk, .reset_n, .ce,
    .address, .read, .write, .writedata, .readdata, .waitrequest, .pwm_out,
    .period_end_event, .seq_end_event, .halted_event);
  pwm_pin_load pwm_pin_load_inst (.clk, .reset_n, .pins(pwm_out), .hi, .rise);
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ==========================================
  // tasks
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic stall();
    failures++;
    $display("Error at %0t: wait limit reached", $time);
    test_done();
  endtask
  task automatic bus(input logic wr, input logic [`ADDR_W-1:0] a, input logic [31:0] d);
    int i;
    i = 0;
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    @(posedge clk);
    while (waitrequest !== 1'b0 && i < 50) begin
      @(posedge clk);
      i++;
    end
    if (i >= 50) stall();
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_on(input bit halt);
    t = 0;
    @(negedge clk);
    while ((halt ? halted_event : period_end_event) !== 1'b1 && t < 5000) begin
      @(negedge clk);
      t++;
    end
    if (t >= 5000) stall();
  endtask
  task automatic setup(input logic [31:0] ctrl, pr, top, len, input logic [15:0] w [4]);
    bus(1'b1, `OFF_CTRL, ctrl);
    bus(1'b1, `OFF_PRESC, pr);
    bus(1'b1, `OFF_TOP, top);
    bus(1'b1, `OFF_SEQ_LEN, len);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 9'h100 + 9'(4 * i), {16'h0, w[i]});
    end
    bus(1'b1, `OFF_TASK, 32'h1);
  endtask
  task automatic meas(input int n);
    logic [15:0] h0 [4];
    logic [15:0] r0 [4];
    // skip the two periods in which new values reach the pins
    repeat (2) wait_on(1'b0);
    h0 = hi;
    r0 = rise;
    clks = 0;
    repeat (n) begin
      wait_on(1'b0);
      clks += t + 1;
    end
    for (int c = 0; c < 4; c++) begin
      dh[c] = hi[c] - h0[c];
      dr[c] = rise[c] - r0[c];
    end
    @(posedge clk);
  endtask
  task automatic expect_run(input logic [15:0] eh [4], input logic [15:0] er [4], input int ec);
    `CHK(clks, ec)
    for (int c = 0; c < 4; c++) begin
      `CHK(dh[c], eh[c])
      `CHK(dr[c], er[c])
    end
  endtask
  task automatic stop_check(input logic [3:0] idle);
    bus(1'b1, `OFF_TASK, 32'h2);
    wait_on(1'b1);
    `CHK(pwm_out, idle)
    @(posedge clk);
  endtask
  // ==========================================
  // sequence
  initial begin
    reset_n = 1'b0;
    ce = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 9'h000;
    writedata = 32'h0;
    failures = 0;
    n_checks = 0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    bus(1'b0, `OFF_TOP, 32'h0);
    `CHK(q, 32'h0000_03FF)
    bus(1'b1, 9'h020, 32'h5);
    bus(1'b0, 9'h020, 32'h0);
    `CHK(q, 32'h0)
    bus(1'b0, `OFF_TASK, 32'h0);
    `CHK(q, 32'h0)
    $display("registers test done");
    setup(32'hA2, 32'h0, 32'hA, 32'h4, '{16'h0000, 16'h0004, 16'h000A, 16'h8004});
    bus(1'b0, 9'h10C, 32'h0);
    `CHK(q, 32'h0000_8004)
    meas(2);
    expect_run('{16'h0, 16'h8, 16'h14, 16'hC}, '{16'h0, 16'h2, 16'h0, 16'h2}, 20);
    bus(1'b0, `OFF_STATUS, 32'h0);
    `CHK(q[2:0], 3'h5)
    bus(1'b1, `OFF_TOP, 32'h14);
    bus(1'b0, `OFF_TOP, 32'h0);
    `CHK(q, 32'h14)
    meas(2);
    `CHK(clks, 20)
    ce <= 1'b0;
    repeat (4) @(posedge clk);
    ce <= 1'b1;
    stop_check(4'hA);
    $display("up mode test done");
    setup(32'h05, 32'h1, 32'h14, 32'h4, '{16'h0003, 16'h0000, 16'h0008, 16'h0006});
    meas(2);
    expect_run('{16'h18, 16'h0, 16'h30, 16'h0}, '{16'h2, 16'h0, 16'h0, 16'h0}, 48);
    stop_check(4'h0);
    $display("up-down wave mode test done");
    setup(32'h00, 32'h0, 32'hA, 32'h2, '{16'h0003, 16'h000C, 16'h0000, 16'h0000});
    meas(2);
    expect_run('{16'h14, 16'h14, 16'h14, 16'h14}, '{16'h0, 16'h0, 16'h0, 16'h0}, 20);
    $display("common sequence test done");
    test_done();
  end
endmodule
bind pwm_wave_counter pwm_wave_counter_sva sva_inst (.clk, .reset_n, .ce, .address, .read,
  .write, .writedata, .readdata, .waitrequest, .pwm_out, .period_end_event, .seq_end_event,
  .halted_event);
`default_nettype wire
